// [logic/cts_decode.sv]
`timescale 1ns/1ps
module cts_decode
(
    input wire logic [7:0] opcode,
    output cts_pkg::cts_dec_t dec
);
    always_comb
    begin
        dec = '0;
        dec.valid = 1'b1;
        case (opcode)
            cts_pkg::OP_PLAIN: dec.words = 2'h0;
            cts_pkg::OP_RD_S:
            begin
                dec.has_src = 1'b1;
                dec.words = 2'h1;
            end
            cts_pkg::OP_RD_D:
            begin
                dec.has_src = 1'b1;
                dec.words = 2'h2;
            end
            cts_pkg::OP_RD_T:
            begin
                dec.has_src = 1'b1;
                dec.words = 2'h3;
            end
            cts_pkg::OP_TA_S:
            begin
                dec.has_src = 1'b1;
                dec.has_dst = 1'b1;
                dec.words = 2'h1;
            end
            cts_pkg::OP_TA_D:
            begin
                dec.has_src = 1'b1;
                dec.has_dst = 1'b1;
                dec.words = 2'h2;
            end
            cts_pkg::OP_TA_T:
            begin
                dec.has_src = 1'b1;
                dec.has_dst = 1'b1;
                dec.words = 2'h3;
            end
            cts_pkg::OP_WR_S:
            begin
                dec.has_dst = 1'b1;
                dec.words = 2'h1;
            end
            cts_pkg::OP_WR_D:
            begin
                dec.has_dst = 1'b1;
                dec.words = 2'h2;
            end
            cts_pkg::OP_WR_T:
            begin
                dec.has_dst = 1'b1;
                dec.words = 2'h3;
            end
            default: dec.valid = 1'b0;
        endcase
    end
endmodule

// [logic/cts_pkg.sv]
package cts_pkg;
    localparam logic [7:0] OP_PLAIN = 8'h32;
    localparam logic [7:0] OP_RD_S = 8'h22;
    localparam logic [7:0] OP_RD_D = 8'h02;
    localparam logic [7:0] OP_RD_T = 8'h06;
    localparam logic [7:0] OP_TA_S = 8'h23;
    localparam logic [7:0] OP_TA_D = 8'h03;
    localparam logic [7:0] OP_TA_T = 8'h07;
    localparam logic [7:0] OP_WR_S = 8'h33;
    localparam logic [7:0] OP_WR_D = 8'h13;
    localparam logic [7:0] OP_WR_T = 8'h17;
    localparam int FLAG_LO = 18;
    localparam int FLAG_HI = 21;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [3:0] AS_BROADCAST = 4'h3;
    localparam logic [3:0] AS_DATA_READ = 4'h1;
    localparam logic [3:0] AS_DATA_WRITE = 4'h2;
    localparam logic [3:0] AS_STATUS = 4'h4;
    typedef struct packed {
        logic valid;
        logic has_src;
        logic has_dst;
        logic [1:0] words;
    } cts_dec_t;
    typedef struct packed {
        logic req;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [1:0] transfer_size;
        logic [3:0] access_status_code;
    } cts_bus_req_t;
endpackage

// [logic/cts_sequencer.sv]
`timescale 1ns/1ps
// Behaviour
// - Opcode byte plus one command word; the word goes out on the bus only.
// - No coprocessor answering the broadcast raises an external memory fault.
// - Narrow ack on broadcast reruns it with low half on both data halves.
// - The rerun broadcast carries broadcast access code and halfword size.
// - Source operands are fetched only after the command word is sent.
// - Stall until coprocessor done, then read the status word.
// - A faulted status read raises an external fault, flags untouched.
// - Fault-free status read copies bits 18..21 into status word flags.
// - After the flag update, write back the result operand if any.
// - Narrow ack on status read keeps upper half, rereads lower at halfword.
// - Interrupts taken from instruction start until the status read begins.
// - Interrupt during traced instruction aborts to trace with PC held.
// - Zero to two operands, each one, two or three words long.
// - Read single, double, triple opcodes are 22, 02, 06 hex.
// - Two-address single, double, triple opcodes are 23, 03, 07 hex.
// - Write single, double, triple opcodes are 33, 13, 17 hex.
module cts_sequencer
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic [31:0] command_word,
    input wire logic [31:0] src_addr,
    input wire logic [31:0] dst_addr,
    input wire logic traced,
    input wire logic irq,
    input wire logic [31:0] psw_in,
    input wire logic bus_ack,
    input wire logic bus_fault,
    input wire logic bus_no_resp,
    input wire logic narrow_port_ack_n,
    input wire logic [31:0] bus_rdata,
    input wire logic done_n,
    output cts_pkg::cts_bus_req_t bus,
    output logic busy,
    output logic finished,
    output logic ext_fault,
    output logic illegal_op,
    output logic irq_taken,
    output logic trace_abort,
    output logic psw_we,
    output logic [31:0] processor_status_word
);
    typedef enum {
        S_IDLE, S_BCAST, S_BCAST16, S_SRC, S_WAIT, S_STAT, S_STAT16,
        S_CAPT, S_DST, S_FETCH
    } cts_state_t;

    cts_state_t state;
    cts_pkg::cts_dec_t dec;
    cts_pkg::cts_dec_t cur;
    logic [31:0] cmd;
    logic [31:0] saddr;
    logic [31:0] daddr;
    logic [1:0] cnt;
    logic [31:0] res [0:2];
    logic [15:0] stat_hi;
    logic [31:0] stat_word;
    logic is_traced;
    logic done_s1;
    logic done_s2;
    logic nack_s1;
    logic nack_s2;
    logic irq_s1;
    logic irq_s2;
    logic irq_window;

    cts_decode u_dec
    (
        .opcode(opcode),
        .dec(dec)
    );

    // Asynchronous pins from the coprocessor and interrupt source.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            nack_s1 <= 1'b0;
            nack_s2 <= 1'b0;
            irq_s1 <= 1'b0;
            irq_s2 <= 1'b0;
        end
        else
        begin
            done_s1 <= ~done_n;
            done_s2 <= done_s1;
            nack_s1 <= ~narrow_port_ack_n;
            nack_s2 <= nack_s1;
            irq_s1 <= irq;
            irq_s2 <= irq_s1;
        end
    end

    // Interrupt window closes once the status read is started.
    assign irq_window = (state == S_BCAST) || (state == S_BCAST16) ||
                        (state == S_SRC) || (state == S_WAIT);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= S_IDLE;
            cur <= '0;
            cmd <= '0;
            saddr <= '0;
            daddr <= '0;
            cnt <= '0;
            is_traced <= 1'b0;
            stat_hi <= '0;
            stat_word <= '0;
            bus <= '0;
            busy <= 1'b0;
            finished <= 1'b0;
            ext_fault <= 1'b0;
            illegal_op <= 1'b0;
            irq_taken <= 1'b0;
            trace_abort <= 1'b0;
            psw_we <= 1'b0;
            processor_status_word <= '0;
        end
        else
        begin
            finished <= 1'b0;
            ext_fault <= 1'b0;
            illegal_op <= 1'b0;
            irq_taken <= 1'b0;
            trace_abort <= 1'b0;
            psw_we <= 1'b0;
            case (state)
                S_IDLE:
                begin
                    if (start && !dec.valid)
                        illegal_op <= 1'b1;
                    else if (start)
                    begin
                        cur <= dec;
                        cmd <= command_word;
                        saddr <= {src_addr[31:2], 2'h0};
                        daddr <= {dst_addr[31:2], 2'h0};
                        is_traced <= traced;
                        cnt <= '0;
                        busy <= 1'b1;
                        bus.req <= 1'b1;
                        bus.write <= 1'b1;
                        bus.addr <= '0;
                        bus.wdata <= command_word;
                        bus.transfer_size <= cts_pkg::SIZE_WORD;
                        bus.access_status_code <= cts_pkg::AS_BROADCAST;
                        state <= S_BCAST;
                    end
                end
                S_BCAST, S_BCAST16:
                begin
                    if (irq_window && irq_s2)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        irq_taken <= 1'b1;
                        trace_abort <= is_traced;
                        state <= S_IDLE;
                    end
                    else if (bus_no_resp || bus_fault)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        ext_fault <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (bus_ack && nack_s2 && state == S_BCAST)
                    begin
                        bus.wdata <= {cmd[15:0], cmd[15:0]};
                        bus.transfer_size <= cts_pkg::SIZE_HALF;
                        state <= S_BCAST16;
                    end
                    else if (bus_ack)
                    begin
                        // Operands follow only the finished broadcast.
                        bus.write <= 1'b0;
                        bus.transfer_size <= cts_pkg::SIZE_WORD;
                        bus.access_status_code <= cts_pkg::AS_DATA_READ;
                        bus.addr <= saddr;
                        bus.req <= cur.has_src;
                        state <= cur.has_src ? S_SRC : S_WAIT;
                    end
                end
                S_SRC:
                begin
                    if (irq_s2)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        irq_taken <= 1'b1;
                        trace_abort <= is_traced;
                        state <= S_IDLE;
                    end
                    else if (bus_fault || bus_no_resp)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        ext_fault <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (bus_ack)
                    begin
                        // The coprocessor snoops each fetched word itself.
                        bus.addr <= bus.addr + 32'h0000_0004;
                        cnt <= cnt + 2'h1;
                        if (cnt + 2'h1 == cur.words)
                        begin
                            bus.req <= 1'b0;
                            state <= S_WAIT;
                        end
                    end
                end
                S_WAIT:
                begin
                    if (irq_s2)
                    begin
                        busy <= 1'b0;
                        irq_taken <= 1'b1;
                        trace_abort <= is_traced;
                        state <= S_IDLE;
                    end
                    else if (done_s2)
                    begin
                        bus.req <= 1'b1;
                        bus.write <= 1'b0;
                        bus.addr <= '0;
                        bus.transfer_size <= cts_pkg::SIZE_WORD;
                        bus.access_status_code <= cts_pkg::AS_STATUS;
                        state <= S_STAT;
                    end
                end
                S_STAT, S_STAT16:
                begin
                    if (bus_fault || bus_no_resp)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        ext_fault <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (bus_ack && nack_s2 && state == S_STAT)
                    begin
                        stat_hi <= bus_rdata[31:16];
                        bus.transfer_size <= cts_pkg::SIZE_HALF;
                        state <= S_STAT16;
                    end
                    else if (bus_ack)
                    begin
                        bus.req <= 1'b0;
                        stat_word <= (state == S_STAT16) ?
                            {stat_hi, bus_rdata[15:0]} : bus_rdata;
                        state <= S_CAPT;
                    end
                end
                S_CAPT:
                begin
                    processor_status_word <= psw_in;
                    processor_status_word[cts_pkg::FLAG_HI:cts_pkg::FLAG_LO]
                        <= stat_word[cts_pkg::FLAG_HI:cts_pkg::FLAG_LO];
                    psw_we <= 1'b1;
                    cnt <= '0;
                    if (cur.has_dst)
                    begin
                        bus.req <= 1'b1;
                        bus.write <= 1'b0;
                        bus.addr <= '0;
                        bus.access_status_code <= cts_pkg::AS_DATA_READ;
                        bus.transfer_size <= cts_pkg::SIZE_WORD;
                        state <= S_FETCH;
                    end
                    else
                    begin
                        busy <= 1'b0;
                        finished <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                S_FETCH:
                begin
                    // Result words come from the coprocessor before storing.
                    if (bus_fault || bus_no_resp)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        ext_fault <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (bus_ack)
                    begin
                        cnt <= cnt + 2'h1;
                        if (cnt + 2'h1 == cur.words)
                        begin
                            bus.write <= 1'b1;
                            bus.addr <= daddr;
                            bus.wdata <= (cnt == 2'h0) ? bus_rdata : res[0];
                            bus.access_status_code <= cts_pkg::AS_DATA_WRITE;
                            cnt <= '0;
                            state <= S_DST;
                        end
                    end
                end
                S_DST:
                begin
                    if (bus_fault || bus_no_resp)
                    begin
                        bus.req <= 1'b0;
                        busy <= 1'b0;
                        ext_fault <= 1'b1;
                        state <= S_IDLE;
                    end
                    else if (bus_ack)
                    begin
                        bus.addr <= bus.addr + 32'h0000_0004;
                        cnt <= cnt + 2'h1;
                        if (cnt + 2'h1 == cur.words)
                        begin
                            bus.req <= 1'b0;
                            busy <= 1'b0;
                            finished <= 1'b1;
                            state <= S_IDLE;
                        end
                        else
                            bus.wdata <= res[cnt + 2'h1];
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Result buffer written as words come back from the coprocessor.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            res[0] <= '0;
            res[1] <= '0;
            res[2] <= '0;
        end
        else if (state == S_FETCH && bus_ack && !bus_fault && !bus_no_resp)
            res[cnt] <= bus_rdata;
    end
endmodule

// [test/cts_coproc_model.sv]
`timescale 1ns/1ps
module cts_coproc_model
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire cts_pkg::cts_bus_req_t bus,
    input wire logic narrow,
    input wire logic absent,
    input wire logic stat_fault,
    input wire logic [1:0] lag,
    input wire logic [31:0] status,
    output logic bus_ack,
    output logic bus_fault,
    output logic bus_no_resp,
    output logic narrow_port_ack_n,
    output logic [31:0] bus_rdata,
    output logic done_n
);
    logic [1:0] wait_cnt;
    logic [4:0] done_cnt;
    logic is_st;
    logic is_bc;
    logic ending;
    assign is_st = bus.access_status_code == cts_pkg::AS_STATUS;
    assign is_bc = bus.access_status_code == cts_pkg::AS_BROADCAST;
    assign ending = bus_ack || bus_fault || bus_no_resp;
    // Held for the whole run so the synchroniser has settled by each ack.
    assign narrow_port_ack_n = !narrow;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_cnt <= 2'h0;
            bus_ack <= 1'b0;
            bus_fault <= 1'b0;
            bus_no_resp <= 1'b0;
            bus_rdata <= 32'h0;
        end
        else if (bus.req && !ending && wait_cnt == lag)
        begin
            wait_cnt <= 2'h0;
            bus_no_resp <= is_bc && absent;
            bus_fault <= is_st && stat_fault;
            bus_ack <= !(is_bc && absent) && !(is_st && stat_fault);
            if (is_st)
                bus_rdata <= bus.transfer_size == cts_pkg::SIZE_HALF
                    ? {2{status[15:0]}} : status;
            else
                bus_rdata <= ~bus.addr;
        end
        else
        begin
            wait_cnt <= (bus.req && !ending) ? wait_cnt + 2'h1 : 2'h0;
            bus_ack <= 1'b0;
            bus_fault <= 1'b0;
            bus_no_resp <= 1'b0;
            // A released bus must not keep showing the last value.
            bus_rdata <= ~bus_rdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            done_n <= 1'b1;
            done_cnt <= 5'h00;
        end
        else
        begin
            if (bus_ack && is_bc)
                done_cnt <= 5'h10;
            else if (done_cnt != 5'h00)
                done_cnt <= done_cnt - 5'h01;
            if (done_cnt == 5'h01)
                done_n <= 1'b0;
            else if (bus.req && is_st)
                done_n <= 1'b1;
        end
    end
endmodule

// [test/cts_sequencer_chk.sv]
`timescale 1ns/1ps
module cts_sequencer_chk
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic bus_ack,
    input wire logic bus_fault,
    input wire logic bus_no_resp,
    input wire logic done_n,
    input wire logic [31:0] psw_in,
    input wire cts_pkg::cts_bus_req_t bus,
    input wire logic busy,
    input wire logic ext_fault,
    input wire logic illegal_op,
    input wire logic irq_taken,
    input wire logic trace_abort,
    input wire logic psw_we,
    input wire logic [31:0] processor_status_word
);
    logic st;
    logic bc;
    assign st = bus.req && bus.access_status_code == cts_pkg::AS_STATUS;
    assign bc = bus.req && bus.access_status_code == cts_pkg::AS_BROADCAST;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    a_start_bcast: assert property (start && !busy |=> illegal_op ||
        (bc && bus.write && bus.transfer_size == cts_pkg::SIZE_WORD))
        else $error("no word broadcast after start");
    a_rerun_dup: assert property (bc && bus.transfer_size ==
        cts_pkg::SIZE_HALF |-> bus.wdata[31:16] == bus.wdata[15:0])
        else $error("halfword broadcast halves differ");
    a_noresp_fault: assert property (bc && bus_no_resp |=> ext_fault)
        else $error("unanswered broadcast without fault");
    a_stat_fault: assert property (st && bus_fault |=>
        ext_fault && !psw_we)
        else $error("faulted status read mishandled");
    a_done_first: assert property (st && !$past(st) &&
        bus.transfer_size == cts_pkg::SIZE_WORD |-> $past(done_n, 2) == 1'b0)
        else $error("status read before done");
    a_irq_window: assert property (st |=> !irq_taken)
        else $error("interrupt taken after status read began");
    a_trace_irq: assert property (trace_abort |-> irq_taken)
        else $error("trace abort without interrupt");
    a_psw_keep: assert property (psw_we |-> processor_status_word
        == {psw_in[31:22], processor_status_word[21:18], psw_in[17:0]})
        else $error("status word bits outside flags changed");
    // An accepted interrupt may withdraw a pending access; nothing else may.
    a_req_hold: assert property (bus.req && !bus_ack && !bus_fault &&
        !bus_no_resp |=> irq_taken ||
        (bus.req && $stable(bus.addr) && $stable(bc)))
        else $error("bus request dropped before answer");
endmodule

bind cts_sequencer cts_sequencer_chk u_chk (.mclk(mclk), .arst_n(arst_n),
    .start(start), .bus_ack(bus_ack), .bus_fault(bus_fault),
    .bus_no_resp(bus_no_resp), .done_n(done_n), .psw_in(psw_in), .bus(bus),
    .busy(busy), .ext_fault(ext_fault), .illegal_op(illegal_op),
    .irq_taken(irq_taken), .trace_abort(trace_abort), .psw_we(psw_we),
    .processor_status_word(processor_status_word));

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic mclk, arst_n, start, traced, irq, bus_ack, bus_fault, bus_no_resp;
    logic narrow_port_ack_n, done_n, busy, finished, ext_fault, illegal_op;
    logic irq_taken, trace_abort, psw_we, narrow, absent, stat_fault;
    logic order_bad;
    logic [7:0] opcode;
    logic [31:0] command_word, psw_in, bus_rdata, status, bc_w, psw_got;
    logic [31:0] processor_status_word;
    logic [1:0] lag, bc_sz;
    logic [5:0] saw;
    cts_pkg::cts_bus_req_t bus;
    int miscompares, samples_checked;
    int cnt [3];
    logic acc;
    logic [3:0] code;
    assign acc = bus.req && bus_ack;
    assign code = bus.access_status_code;

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // Operand addresses sit on word boundaries.
    cts_sequencer dut (.mclk(mclk), .arst_n(arst_n), .start(start),
        .opcode(opcode), .command_word(command_word),
        .src_addr(32'h10000000), .dst_addr(32'h20000000), .traced(traced),
        .irq(irq), .psw_in(psw_in), .bus_ack(bus_ack), .bus_fault(bus_fault),
        .bus_no_resp(bus_no_resp), .narrow_port_ack_n(narrow_port_ack_n),
        .bus_rdata(bus_rdata), .done_n(done_n), .bus(bus), .busy(busy),
        .finished(finished), .ext_fault(ext_fault), .illegal_op(illegal_op),
        .irq_taken(irq_taken), .trace_abort(trace_abort), .psw_we(psw_we),
        .processor_status_word(processor_status_word));

    cts_coproc_model partner (.mclk(mclk), .arst_n(arst_n), .bus(bus),
        .narrow(narrow), .absent(absent), .stat_fault(stat_fault),
        .lag(lag), .status(status), .bus_ack(bus_ack), .bus_fault(bus_fault),
        .bus_no_resp(bus_no_resp), .narrow_port_ack_n(narrow_port_ack_n),
        .bus_rdata(bus_rdata), .done_n(done_n));

    always @(posedge mclk)
    begin
        if (acc && code == cts_pkg::AS_BROADCAST)
        begin
            bc_w <= bus.wdata;
            bc_sz <= bus.transfer_size;
        end
        if (acc && code == cts_pkg::AS_DATA_READ && bus.addr[31:28] == 4'h1)
        begin
            cnt[0] <= cnt[0] + 1;
            order_bad <= order_bad | (cnt[2] != 0);
        end
        if (acc && code == cts_pkg::AS_DATA_WRITE)
        begin
            cnt[1] <= cnt[1] + 1;
            order_bad <= order_bad | !saw[5];
        end
        if (acc && code == cts_pkg::AS_STATUS)
            cnt[2] <= cnt[2] + 1;
        if (psw_we)
            psw_got <= processor_status_word;
        saw <= saw | {psw_we, trace_abort, irq_taken, illegal_op, ext_fault,
            finished};
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic issue(input logic [7:0] op, input logic [31:0] cmd,
        input logic arm);
        int k;
        @(posedge mclk);
        #1;
        cnt = '{0, 0, 0};
        saw = 6'h00;
        order_bad = 1'b0;
        @(posedge mclk);
        start <= 1'b1;
        opcode <= op;
        command_word <= cmd;
        irq <= arm;
        @(posedge mclk);
        start <= 1'b0;
        for (k = 0; k < 400 && saw[3:0] == 4'h0; k++)
        begin
            @(posedge mclk);
            #1;
        end
        if (saw[3:0] == 4'h0)
        begin
            miscompares++;
            end_sim();
        end
        irq <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic t_opcodes();
        logic [7:0] ops [10];
        logic [31:0] st;
        int w;
        ops = '{8'h22, 8'h02, 8'h06, 8'h23, 8'h03, 8'h07, 8'h33, 8'h13,
            8'h17, 8'h32};
        for (int i = 0; i < 10; i++)
        begin
            w = (i < 9) ? i % 3 + 1 : 0;
            st = 32'hA5A5A5A5 ^ (32'(i) << 18);
            lag <= 2'(i);
            status <= st;
            issue(ops[i], 32'h0C0D0000 + 32'(i), 1'b0);
            chk(32'(cnt[0]), 32'((i < 6) ? w : 0));
            chk(32'(cnt[1]), 32'((i > 2) ? w : 0));
            chk(bc_w, 32'h0C0D0000 + 32'(i));
            chk({30'h0, bc_sz}, {30'h0, cts_pkg::SIZE_WORD});
            chk(psw_got, {psw_in[31:22], st[21:18], psw_in[17:0]});
            chk({31'h0, order_bad}, 32'h0);
            chk({26'h0, saw}, 32'h21);
        end
        issue(8'h70, 32'h0, 1'b0);
        chk({26'h0, saw}, 32'h04);
    endtask

    task automatic t_narrow();
        narrow <= 1'b1;
        status <= 32'h0028BEEF;
        repeat (4) @(posedge mclk);
        issue(8'h33, 32'hCAFE1234, 1'b0);
        chk(bc_w, 32'h12341234);
        chk({30'h0, bc_sz}, {30'h0, cts_pkg::SIZE_HALF});
        chk(32'(cnt[2]), 32'h2);
        chk(psw_got, {psw_in[31:22], 4'hA, psw_in[17:0]});
        narrow <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    task automatic t_faults();
        absent <= 1'b1;
        issue(8'h22, 32'h1, 1'b0);
        chk({26'h0, saw}, 32'h02);
        chk(32'(cnt[0]), 32'h0);
        absent <= 1'b0;
        stat_fault <= 1'b1;
        issue(8'h23, 32'h2, 1'b0);
        chk({26'h0, saw}, 32'h02);
        chk(32'(cnt[1]), 32'h0);
        stat_fault <= 1'b0;
    endtask

    task automatic t_irq();
        for (int t = 0; t < 2; t++)
        begin
            traced <= t[0];
            lag <= 2'h3;
            issue(8'h22, 32'h3, 1'b1);
            chk({26'h0, saw}, t ? 32'h18 : 32'h08);
            chk(32'(cnt[2]), 32'h0);
            chk({31'h0, busy}, 32'h0);
        end
    endtask

    initial
    begin
        arst_n = 1'b0;
        start = 1'b0;
        opcode = 8'h00;
        command_word = 32'h0;
        traced = 1'b0;
        irq = 1'b0;
        psw_in = 32'h12345678;
        narrow = 1'b0;
        absent = 1'b0;
        stat_fault = 1'b0;
        lag = 2'h0;
        status = 32'h0;
        miscompares = 0;
        samples_checked = 0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        t_opcodes();
        t_narrow();
        t_faults();
        t_irq();
        end_sim();
    end
endmodule
